// *** verilog/kpgo_pkg.sv ***
// Package: register map, reset values and widths of the keypad port output block
`default_nettype none
package kpgo_pkg;
   // Register offsets on the host register port
   localparam logic [7:0] LED_ENABLE_OFS = 8'h31;
   localparam logic [7:0] ROW_DIR_OFS = 8'h34;
   localparam logic [7:0] COL_DIR_OFS = 8'h35;
   localparam logic [7:0] ROW_DRIVE_STYLE_OFS = 8'h36;
   localparam logic [7:0] COL_DRIVE_STYLE_OFS = 8'h37;
   localparam logic [7:0] ROW_SUPPLY_SELECT_OFS = 8'h38;
   localparam logic [7:0] COL_SUPPLY_SELECT_OFS = 8'h39;
   localparam logic [7:0] ROW_OUTPUT_VALUE_OFS = 8'h3A;
   localparam logic [7:0] COL_OUTPUT_VALUE_OFS = 8'h3B;

   // Values after reset
   localparam logic [7:0] LED_ENABLE_RST = 8'h00;
   localparam logic [7:0] ROW_DIR_RST = 8'h00;
   localparam logic [7:0] COL_DIR_RST = 8'h00;
   localparam logic [7:0] ROW_DRIVE_STYLE_RST = 8'hFF;
   localparam logic [7:0] COL_DRIVE_STYLE_RST = 8'h0F;
   localparam logic [7:0] ROW_SUPPLY_SELECT_RST = 8'h00;
   localparam logic [7:0] COL_SUPPLY_SELECT_RST = 8'h00;
   localparam logic [7:0] ROW_OUTPUT_VALUE_RST = 8'hFF;
   localparam logic [7:0] COL_OUTPUT_VALUE_RST = 8'hFF;

   // Field layout
   localparam int LINE_COUNT = 8;
   localparam int LED_LINE_LO = 4;
   localparam logic [7:0] COL_DRIVE_WRITABLE = 8'h0F;
   localparam logic [7:0] LED_ENABLE_WRITABLE = 8'h0F;

   // Drive style encoding of one style bit
   typedef enum logic {
      KPGO_OPEN_DRAIN = 1'b0,
      KPGO_PUSH_PULL = 1'b1
   } kpgo_style_t;
endpackage : kpgo_pkg
`default_nettype wire

// *** verilog/kpgo_pin_cell.sv ***
// One port pin: output driver stage and three-stage input synchroniser
`default_nettype none
module kpgo_pin_cell (
   input wire logic mclk, // Block clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic dir_out, // 1 = pin is an output
   input wire logic gpio_sel, // 1 = general function owns the pin
   input wire logic push_pull, // Effective drive style
   input wire logic out_value, // Level software asks for
   input wire logic pin_i, // Pad level seen from outside
   output logic pin_o, // Pad output level
   output logic pin_oe, // Pad output enable, high while driving
   output logic level // Filtered pad level
);
   logic drive_d;
   logic oe_d;
   logic o_q;
   logic oe_q;
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   // Active drive only for general outputs; open drain releases on 1
   assign drive_d = dir_out & gpio_sel;
   assign oe_d = drive_d & (push_pull | ~out_value);

   // Output stage registers
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         o_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         o_q <= drive_d & out_value & push_pull;
         oe_q <= oe_d;
      end
   end

   // Input synchroniser; level moves once stages two and three agree
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            level_q <= s3_q;
      end
   end

   assign pin_o = o_q;
   assign pin_oe = oe_q;
   assign level = level_q;
endmodule : kpgo_pin_cell
`default_nettype wire

// *** verilog/kpgo_port.sv ***
// Keypad port output configuration: registers and sixteen pin drivers
`default_nettype none
// Function
// - Row drive register: 0 open-drain, 1 push-pull
// - Column bits 3..0 pick open-drain or push-pull
// - Columns 7..4 open-drain; style bits ignore writes
// - Row supply select, reset to main supply
// - Column supply select, reset to main supply
// - Row value register sets row pin level
// - Column value register sets column pin level
// - Columns 7..4 release on 1, external pull-up
// - Outputs act only when direction bit is 1
// - LED enable hands columns 7..4 to LED driver
module kpgo_port #(
   parameter int NUM_LINES = 8 // Pins per group
) (
   input wire logic mclk, // Block clock, 250 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic reg_wr, // Register write strobe, one cycle
   input wire logic reg_rd, // Register read strobe, one cycle
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
   input wire logic [7:0] line_y_i, // Row pad input levels
   output logic [7:0] line_y_o, // Row pad output levels
   output logic [7:0] line_y_oe, // Row pad output enables
   input wire logic [7:0] line_x_i, // Column pad input levels
   output logic [7:0] line_x_o, // Column pad output levels
   output logic [7:0] line_x_oe, // Column pad output enables
   output logic [7:0] line_y_alt_supply, // Row pads on alternate logic supply
   output logic [7:0] line_x_alt_supply, // Column pads on alternate logic supply
   output logic [3:0] line_x_led_mode, // Columns 7..4 handed to LED driver
   output logic [7:0] line_y_level, // Filtered row pad levels
   output logic [7:0] line_x_level // Filtered column pad levels
);
   // Register bytes are fixed at eight pins per group
   if (NUM_LINES != kpgo_pkg::LINE_COUNT)
   begin : g_width_check
      $error("kpgo_port serves exactly eight lines per group");
   end

   // LED columns must be the upper four lines of the column group
   if (kpgo_pkg::LED_LINE_LO + 4 != NUM_LINES)
   begin : g_led_check
      $error("kpgo_port expects LED columns on the upper four lines");
   end

   logic [7:0] led_enable_q;
   logic [7:0] led_enable_d;
   logic [7:0] row_dir_q;
   logic [7:0] row_dir_d;
   logic [7:0] col_dir_q;
   logic [7:0] col_dir_d;
   logic [7:0] row_drive_style_q;
   logic [7:0] row_drive_style_d;
   logic [7:0] column_drive_style_q;
   logic [7:0] column_drive_style_d;
   logic [7:0] row_supply_select_q;
   logic [7:0] row_supply_select_d;
   logic [7:0] column_supply_select_q;
   logic [7:0] column_supply_select_d;
   logic [7:0] row_output_value_q;
   logic [7:0] row_output_value_d;
   logic [7:0] column_output_value_q;
   logic [7:0] column_output_value_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   wire hit_led;
   wire hit_row_dir;
   wire hit_col_dir;
   wire hit_row_style;
   wire hit_col_style;
   wire hit_row_supply;
   wire hit_col_supply;
   wire hit_row_value;
   wire hit_col_value;
   wire [7:0] col_style_eff;
   wire [7:0] col_gpio_sel;
   wire [7:0] row_gpio_sel;
   wire wr_led;
   wire wr_row_dir;
   wire wr_col_dir;
   wire wr_row_style;
   wire wr_col_style;
   wire wr_row_supply;
   wire wr_col_supply;
   wire wr_row_value;
   wire wr_col_value;
   wire [7:0] led_wdata;
   wire [7:0] col_style_wdata;
   wire [7:0] rd_led;
   wire [7:0] rd_row_dir;
   wire [7:0] rd_col_dir;
   wire [7:0] rd_row_style;
   wire [7:0] rd_col_style;
   wire [7:0] rd_row_supply;
   wire [7:0] rd_col_supply;
   wire [7:0] rd_row_value;
   wire [7:0] rd_col_value;

   // Address decode
   assign hit_led = (reg_addr == kpgo_pkg::LED_ENABLE_OFS);
   assign hit_row_dir = (reg_addr == kpgo_pkg::ROW_DIR_OFS);
   assign hit_col_dir = (reg_addr == kpgo_pkg::COL_DIR_OFS);
   assign hit_row_style = (reg_addr == kpgo_pkg::ROW_DRIVE_STYLE_OFS);
   assign hit_col_style = (reg_addr == kpgo_pkg::COL_DRIVE_STYLE_OFS);
   assign hit_row_supply = (reg_addr == kpgo_pkg::ROW_SUPPLY_SELECT_OFS);
   assign hit_col_supply = (reg_addr == kpgo_pkg::COL_SUPPLY_SELECT_OFS);
   assign hit_row_value = (reg_addr == kpgo_pkg::ROW_OUTPUT_VALUE_OFS);
   assign hit_col_value = (reg_addr == kpgo_pkg::COL_OUTPUT_VALUE_OFS);

   // Per-register write strobes
   assign wr_led = reg_wr & hit_led;
   assign wr_row_dir = reg_wr & hit_row_dir;
   assign wr_col_dir = reg_wr & hit_col_dir;
   assign wr_row_style = reg_wr & hit_row_style;
   assign wr_col_style = reg_wr & hit_col_style;
   assign wr_row_supply = reg_wr & hit_row_supply;
   assign wr_col_supply = reg_wr & hit_col_supply;
   assign wr_row_value = reg_wr & hit_row_value;
   assign wr_col_value = reg_wr & hit_col_value;

   // Write data with read-only bits held at zero
   assign led_wdata = reg_wdata & kpgo_pkg::LED_ENABLE_WRITABLE;
   assign col_style_wdata = reg_wdata & kpgo_pkg::COL_DRIVE_WRITABLE;

   // Next values of the LED enable and direction registers
   assign led_enable_d = wr_led ?
      led_wdata : led_enable_q;
   assign row_dir_d = wr_row_dir ? reg_wdata : row_dir_q;
   assign col_dir_d = wr_col_dir ? reg_wdata : col_dir_q;

   // Next values of the drive style registers; upper column bits stay zero
   assign row_drive_style_d = wr_row_style ?
      reg_wdata : row_drive_style_q;
   assign column_drive_style_d = wr_col_style ?
      col_style_wdata : column_drive_style_q;

   // Next values of the supply select registers
   assign row_supply_select_d = wr_row_supply ?
      reg_wdata : row_supply_select_q;
   assign column_supply_select_d = wr_col_supply ?
      reg_wdata : column_supply_select_q;

   // Next values of the output value registers
   assign row_output_value_d = wr_row_value ?
      reg_wdata : row_output_value_q;
   assign column_output_value_d = wr_col_value ?
      reg_wdata : column_output_value_q;

   // LED enable register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         led_enable_q <= kpgo_pkg::LED_ENABLE_RST;
      else
         led_enable_q <= led_enable_d;
   end

   // Row direction register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         row_dir_q <= kpgo_pkg::ROW_DIR_RST;
      else
         row_dir_q <= row_dir_d;
   end

   // Column direction register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         col_dir_q <= kpgo_pkg::COL_DIR_RST;
      else
         col_dir_q <= col_dir_d;
   end

   // Row drive style register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         row_drive_style_q <= kpgo_pkg::ROW_DRIVE_STYLE_RST;
      else
         row_drive_style_q <= row_drive_style_d;
   end

   // Column drive style register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         column_drive_style_q <= kpgo_pkg::COL_DRIVE_STYLE_RST;
      else
         column_drive_style_q <= column_drive_style_d;
   end

   // Row supply select register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         row_supply_select_q <= kpgo_pkg::ROW_SUPPLY_SELECT_RST;
      else
         row_supply_select_q <= row_supply_select_d;
   end

   // Column supply select register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         column_supply_select_q <= kpgo_pkg::COL_SUPPLY_SELECT_RST;
      else
         column_supply_select_q <= column_supply_select_d;
   end

   // Row output value register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         row_output_value_q <= kpgo_pkg::ROW_OUTPUT_VALUE_RST;
      else
         row_output_value_q <= row_output_value_d;
   end

   // Column output value register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         column_output_value_q <= kpgo_pkg::COL_OUTPUT_VALUE_RST;
      else
         column_output_value_q <= column_output_value_d;
   end

   // Read mux; unmapped offsets read zero, offsets never overlap
   assign rd_led = hit_led ? led_enable_q : 8'h00;
   assign rd_row_dir = hit_row_dir ? row_dir_q : 8'h00;
   assign rd_col_dir = hit_col_dir ? col_dir_q : 8'h00;
   assign rd_row_style = hit_row_style ? row_drive_style_q : 8'h00;
   assign rd_col_style = hit_col_style ? column_drive_style_q : 8'h00;
   assign rd_row_supply = hit_row_supply ? row_supply_select_q : 8'h00;
   assign rd_col_supply = hit_col_supply ? column_supply_select_q : 8'h00;
   assign rd_row_value = hit_row_value ? row_output_value_q : 8'h00;
   assign rd_col_value = hit_col_value ? column_output_value_q : 8'h00;
   assign rdata_d = rd_led | rd_row_dir | rd_col_dir |
      rd_row_style | rd_col_style |
      rd_row_supply | rd_col_supply |
      rd_row_value | rd_col_value;

   // Read data holds until the next read strobe
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (reg_rd)
         rdata_q <= rdata_d;
   end

   assign reg_rdata = rdata_q;

   // Upper columns forced open drain whatever the style bits hold
   assign col_style_eff = {4'h0, column_drive_style_q[3:0]};

   // LED function takes columns 7..4 away from the general output path
   assign col_gpio_sel = {~led_enable_q[3:0], 4'hF};
   assign row_gpio_sel = 8'hFF;

   // Row pin drivers
   for (genvar gi = 0; gi < NUM_LINES; gi++)
   begin : g_row
      kpgo_pin_cell u_cell (
         .mclk(mclk),
         .rstn(rstn),
         .dir_out(row_dir_q[gi]),
         .gpio_sel(row_gpio_sel[gi]),
         .push_pull(row_drive_style_q[gi]),
         .out_value(row_output_value_q[gi]),
         .pin_i(line_y_i[gi]),
         .pin_o(line_y_o[gi]),
         .pin_oe(line_y_oe[gi]),
         .level(line_y_level[gi])
      );
   end

   // Column pin drivers
   for (genvar gj = 0; gj < NUM_LINES; gj++)
   begin : g_col
      kpgo_pin_cell u_cell (
         .mclk(mclk),
         .rstn(rstn),
         .dir_out(col_dir_q[gj]),
         .gpio_sel(col_gpio_sel[gj]),
         .push_pull(col_style_eff[gj]),
         .out_value(column_output_value_q[gj]),
         .pin_i(line_x_i[gj]),
         .pin_o(line_x_o[gj]),
         .pin_oe(line_x_oe[gj]),
         .level(line_x_level[gj])
      );
   end

   // Supply rail and LED hand-off straight from registers
   assign line_y_alt_supply = row_supply_select_q;
   assign line_x_alt_supply = column_supply_select_q;
   assign line_x_led_mode = led_enable_q[3:0];
endmodule : kpgo_port
`default_nettype wire

// *** bench/kpgo_pads.sv ***
// External loads on the port: a pull-up resistor on every line
`default_nettype none
module kpgo_pads (
   input wire logic [15:0] pin_o, // Levels driven by the block
   input wire logic [15:0] pin_oe, // Drive enables from the block
   output logic [15:0] pin_level // Wire level seen on the pads
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released line floats up to the pull-up level
   assign pin_level = (pin_o & pin_oe) | ~pin_oe;
endmodule : kpgo_pads
`default_nettype wire

// *** bench/kpgo_port_assertions.sv ***
// Concurrent checks on the ports of the keypad port output block
`default_nettype none
module kpgo_port_assertions (
   input wire logic mclk, // Block clock
   input wire logic rstn, // Reset, active low
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic [7:0] line_y_o, // Row levels
   input wire logic [7:0] line_y_oe, // Row enables
   input wire logic [7:0] line_x_o, // Column levels
   input wire logic [7:0] line_x_oe, // Column enables
   input wire logic [7:0] line_y_alt_supply, // Row supply choice
   input wire logic [7:0] line_x_alt_supply, // Column supply choice
   input wire logic [3:0] line_x_led_mode // Columns handed to LED driver
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Pin drive relations
   out_needs_oe_a: assert property (((line_y_o & ~line_y_oe) == 8'h00) &&
      ((line_x_o & ~line_x_oe) == 8'h00)) else $error("pin high without enable");
   col_upper_od_a: assert property (line_x_o[7:4] == 4'h0)
      else $error("upper column driven high");
   led_release_a: assert property ((line_x_led_mode & $past(line_x_led_mode)
      & line_x_oe[7:4]) == 4'h0) else $error("LED column still driven");
   dir_reset_a: assert property ($rose(rstn) |-> line_y_oe == 8'h00 &&
      line_x_oe == 8'h00) else $error("pin driven after reset");
   // Register effects
   row_supply_a: assert property (reg_wr && reg_addr == 8'h38 |=>
      line_y_alt_supply == $past(reg_wdata)) else $error("row supply not applied");
   col_supply_a: assert property (reg_wr && reg_addr == 8'h39 |=>
      line_x_alt_supply == $past(reg_wdata)) else $error("column supply not applied");
   row_low_a: assert property (reg_wr && reg_addr == 8'h3A && reg_wdata == 8'h00
      |=> ##1 line_y_o == 8'h00) else $error("row not driven low");
   col_low_a: assert property (reg_wr && reg_addr == 8'h3B && reg_wdata == 8'h00
      |=> ##1 line_x_o == 8'h00) else $error("column not driven low");
   col_style_rd_a: assert property (reg_rd && reg_addr == 8'h37 |=>
      reg_rdata[7:4] == 4'h0) else $error("upper style bits not zero");
endmodule : kpgo_port_assertions
bind kpgo_port kpgo_port_assertions kpgo_port_assertions_i (.mclk, .rstn, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .line_y_o, .line_y_oe, .line_x_o, .line_x_oe,
   .line_y_alt_supply, .line_x_alt_supply, .line_x_led_mode);
`default_nettype wire

// *** bench/kpgo_port_bench.sv ***
// Self-checking bench for the keypad port output block
`default_nettype none
module kpgo_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] rdata, y_o, y_oe, x_o, x_oe, y_alt, x_alt, y_lvl, x_lvl;
   logic [3:0] led;
   logic [15:0] pad;
   int n_fail = 0;
   int compares = 0;
   // Clock and design under test with its pads
   always #2 mclk = ~mclk;
   kpgo_port kpgo_port_i (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .line_y_i(pad[7:0]),
      .line_y_o(y_o), .line_y_oe(y_oe), .line_x_i(pad[15:8]), .line_x_o(x_o),
      .line_x_oe(x_oe), .line_y_alt_supply(y_alt), .line_x_alt_supply(x_alt),
      .line_x_led_mode(led), .line_y_level(y_lvl), .line_x_level(x_lvl));
   kpgo_pads kpgo_pads_i (.pin_o({x_o, y_o}), .pin_oe({x_oe, y_oe}), .pin_level(pad));
   task print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      chk(rdata, exp);
   endtask : chk_rd
   task t_reset;
      chk_rd(8'h36, kpgo_pkg::ROW_DRIVE_STYLE_RST);
      chk_rd(8'h37, kpgo_pkg::COL_DRIVE_STYLE_RST);
      chk_rd(8'h38, 8'h00);
      chk_rd(8'h39, 8'h00);
      chk_rd(8'h3A, kpgo_pkg::ROW_OUTPUT_VALUE_RST);
      chk_rd(8'h3B, kpgo_pkg::COL_OUTPUT_VALUE_RST);
      chk_rd(8'h35, 8'h00);
      chk_rd(8'h31, 8'h00);
      chk_rd(8'h00, 8'h00);
      chk(y_oe | x_oe, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task t_regs;
      wr(8'h37, 8'hFF);
      chk_rd(8'h37, 8'h0F);
      wr(8'h38, 8'h5A);
      wr(8'h39, 8'hC3);
      chk_rd(8'h38, 8'h5A);
      chk_rd(8'h39, 8'hC3);
      chk(y_alt, 8'h5A);
      chk(x_alt, 8'hC3);
      $display("test regs done");
   endtask : t_regs
   task t_rerst;
      @(negedge mclk);
      rstn = 1'b0;
      repeat (2) @(negedge mclk);
      chk(y_alt | x_alt, 8'h00);
      rstn = 1'b1;
      chk_rd(8'h38, 8'h00);
      chk_rd(8'h39, 8'h00);
      chk(y_oe | x_oe, 8'h00);
      $display("test mid-run reset done");
   endtask : t_rerst
   task t_pins;
      wr(8'h34, 8'hFF);
      wr(8'h35, 8'hFF);
      wr(8'h36, 8'hF0);
      wr(8'h3A, 8'hAA);
      wr(8'h37, 8'hFC);
      wr(8'h3B, 8'hA5);
      repeat (6) @(negedge mclk);
      chk(y_oe, 8'hF0 | ~8'hAA);
      chk(y_o, 8'hF0 & 8'hAA);
      chk(x_oe, 8'h0C | ~8'hA5);
      chk(x_o, 8'h0C & 8'hA5);
      chk(y_lvl, 8'hAA);
      chk(x_lvl, 8'hA5);
      wr(8'h3A, 8'h00);
      wr(8'h3B, 8'h00);
      wr(8'h31, 8'hFF);
      repeat (3) @(negedge mclk);
      chk(y_oe, 8'hFF);
      chk(x_oe, 8'h0F);
      chk({4'h0, led}, 8'h0F);
      wr(8'h34, 8'h00);
      wr(8'h31, 8'h00);
      repeat (3) @(negedge mclk);
      chk(y_oe, 8'h00);
      chk(x_oe, 8'hFF);
      $display("test pins done");
   endtask : t_pins
   // Main sequence
   initial
   begin
      repeat (3) @(negedge mclk);
      rstn = 1'b1;
      t_reset;
      t_regs;
      t_rerst;
      t_pins;
      print_verdict;
   end
   // Watchdog
   initial
   begin
      #20000;
      n_fail++;
      print_verdict;
   end
endmodule : kpgo_port_bench
`default_nettype wire
